// ===== hw/pllck_pkg.sv
/*
 package for the pll clock generator: register map, field positions, reset values and divider counts.
 assumes an axi4-lite master on the same 20 MHz clock.
*/
package pllck_pkg;

   // register byte offsets
   localparam logic [7:0] PLLCK_CTRL_OFS   = 8'h00;
   localparam logic [7:0] PLLCK_STATUS_OFS = 8'h04;

   // control field positions
   localparam int PLLCK_HALF_BIT   = 0;
   localparam int PLLCK_THIRD_BIT  = 1;
   localparam int PLLCK_DOUBLE_BIT = 2;
   localparam int PLLCK_ECKDIS_BIT = 3;
   localparam int PLLCK_CPUDIV_LSB = 4;

   // reset values and cpu divider limit
   localparam logic [1:0] PLLCK_MCK_SEL_RST = 2'h0;
   localparam logic [2:0] PLLCK_CPUDIV_RST  = 3'h0;
   localparam logic [2:0] PLLCK_CPUDIV_MAX  = 3'h6;

   // pll: crystal times this factor gives the raw pll output
   localparam int PLLCK_PLL_MULT = 2400;
   // final divisions of the scaled master clock, in master clock cycles
   localparam int PLLCK_SLOW_CLOCK_32K_DIV_HALF  = PLLCK_PLL_MULT / 2;
   localparam int PLLCK_SLOW_CLOCK_32K_DIV_THIRD = PLLCK_PLL_MULT / 3;
   localparam int PLLCK_SLOW_CLOCK_32K_DIV_QUART = PLLCK_PLL_MULT / 4;
   // brownout master clock is the crystal times 32 * 7/8 (112 kHz class)
   localparam int PLLCK_BROWN_MCK_MULT = 28;

   typedef enum logic [1:0]
   {
      PLLCK_DIV2 = 2'h2,
      PLLCK_DIV3 = 2'h1,
      PLLCK_DIV4 = 2'h0
   } pllck_mck_sel_type;

   typedef struct packed
   {
      logic master_clock;
      logic engine;
      logic converter;
      logic filter;
      logic cpu;
      logic emulator;
      logic slow32k;
   } pllck_enables_type;

endpackage : pllck_pkg

// ===== hw/pllck_top.sv
/*
 pll clock generator modelled as one-cycle enable pulses on the 20 MHz system clock.
 one enable stands for one rising edge of each derived clock, scaled by the aclk rate.
 selects, sleep, brownout and the cpu, emulator and engine settings change only at a frame boundary.
 assumes sleep and brownout levels from another clock domain, software on axi4-lite.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// - master clock comes from crystal multiplied by 2400 in the pll
// - master clock divider is 2, 3 or 4 from the two select bits
// - power-on reset clears both select bits, divide-by-four
// - divide-by-two: engine clock 10 MHz with double bit, 5 MHz without
// - divide-by-two: converter and filter clocks stay at 5 MHz
// - divide-by-three: engine, converter, filter and cpu max clocks 6.6 MHz
// - cpu clock is scaled master clock over two to the divider plus two
// - emulator clock runs at twice the cpu clock, suppressed when disabled
// - sleep forces both divider select inputs low
// - brownout: pll and engine clock off, master 112 kHz, others 28 kHz; code keeps cpu divider and emulator, slow32k is master over 28
// - derived clocks share rising edges, all from one master count
// - 32 kHz clock derived from scaled master clock in every setting
// - cpu counter/timers run from the cpu clock
module pllck_top
   import pllck_pkg::*;
(
   // system
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // power modes, asynchronous
   input  wire logic        sleep_mode,
   input  wire logic        brownout_mode,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // clock enables, one cycle each
   output pllck_enables_type clk_en,
   output logic              timer_tick
);

   logic [1:0]  mck_sel_r;
   logic        engine_clock_double_r;
   logic        emulator_clock_disable_r;
   logic [2:0]  cpu_clock_divider_r;
   logic [1:0]  sleep_sync_r;
   logic [1:0]  brown_sync_r;
   logic [1:0]  active_sel_r;
   logic        active_brown_r;
   logic [11:0] mck_cnt_r;
   logic [11:0] mck_cnt_nxt;
   logic [11:0] mck_period;
   logic        mck_tick;
   logic [8:0]  cpu_cnt_r;
   logic [8:0]  cpu_mask;
   logic [2:0]  cpu_div_act_r;
   logic        emu_dis_act_r;
   logic        double_act_r;
   logic [3:0]  conv_div;
   logic [3:0]  eng_div;
   logic [3:0]  sub_cnt_r;
   logic        frame_end;
   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   pllck_enables_type en_nxt;

   // input synchronisers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sleep_sync_r <= 2'h0;
         brown_sync_r <= 2'h0;
      end
      else
      begin
         sleep_sync_r <= {sleep_sync_r[0], sleep_mode};
         brown_sync_r <= {brown_sync_r[0], brownout_mode};
      end
   end

   // axi write channel, address and data taken in either order
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end
      else if (aw_hold_r && w_hold_r)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else if (aw_hold_r && w_hold_r)
      begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr_r[7:2] == PLLCK_CTRL_OFS[7:2] || aw_addr_r[7:2] == PLLCK_STATUS_OFS[7:2])
            s_axi_bresp <= 2'h0;
         else
            s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register; values outside 0..6 clamp the cpu divider
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mck_sel_r                <= PLLCK_MCK_SEL_RST;
         engine_clock_double_r    <= 1'b0;
         emulator_clock_disable_r <= 1'b1;
         cpu_clock_divider_r      <= PLLCK_CPUDIV_RST;
      end
      else if (aw_hold_r && w_hold_r && aw_addr_r[7:2] == PLLCK_CTRL_OFS[7:2] && w_strb_r[0])
      begin
         mck_sel_r                <= {w_data_r[PLLCK_HALF_BIT], w_data_r[PLLCK_THIRD_BIT]};
         engine_clock_double_r    <= w_data_r[PLLCK_DOUBLE_BIT];
         emulator_clock_disable_r <= w_data_r[PLLCK_ECKDIS_BIT];
         if (w_data_r[PLLCK_CPUDIV_LSB +: 3] > PLLCK_CPUDIV_MAX)
            cpu_clock_divider_r <= PLLCK_CPUDIV_MAX;
         else
            cpu_clock_divider_r <= w_data_r[PLLCK_CPUDIV_LSB +: 3];
      end
   end

   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         if (s_axi_araddr[7:2] == PLLCK_CTRL_OFS[7:2])
            s_axi_rdata <= {25'h0, cpu_clock_divider_r, emulator_clock_disable_r,
                            engine_clock_double_r, mck_sel_r[0], mck_sel_r[1]};
         else if (s_axi_araddr[7:2] == PLLCK_STATUS_OFS[7:2])
            s_axi_rdata <= {27'h0, brown_sync_r[1], sleep_sync_r[1], active_brown_r, active_sel_r};
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // settings take effect only at a 32 kHz boundary so no derived pulse is cut short
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active_sel_r   <= PLLCK_MCK_SEL_RST;
         active_brown_r <= 1'b0;
      end
      else if (frame_end)
      begin
         active_sel_r   <= sleep_sync_r[1] ? 2'h0 : mck_sel_r;
         active_brown_r <= brown_sync_r[1];
      end
   end

   // cpu rate and emulator settings wait for the same boundary; applied mid-frame they
   // could cut a running cpu or emulator period short
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cpu_div_act_r <= PLLCK_CPUDIV_RST;
      else if (frame_end)
         cpu_div_act_r <= cpu_clock_divider_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         emu_dis_act_r <= 1'b1;
      else if (frame_end)
         emu_dis_act_r <= emulator_clock_disable_r;
   end

   // the double bit only matters in divide-by-two, but follows the boundary as well
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         double_act_r <= 1'b0;
      else if (frame_end)
         double_act_r <= engine_clock_double_r;
   end

   // master clock pacing, 20 MHz base
   // one 32 kHz period holds mck_period master ticks
   always_comb
   begin
      case (active_sel_r)
         PLLCK_DIV2: mck_period = 12'(PLLCK_SLOW_CLOCK_32K_DIV_HALF);
         PLLCK_DIV3: mck_period = 12'(PLLCK_SLOW_CLOCK_32K_DIV_THIRD);
         default:    mck_period = 12'(PLLCK_SLOW_CLOCK_32K_DIV_QUART);
      endcase
      if (active_brown_r)
         mck_period = 12'(PLLCK_BROWN_MCK_MULT);
   end

   // each aclk cycle stands for one master tick: aclk cannot reach 40 MHz, so the pll
   // factor shows only in the master ticks counted per 32 kHz period
   assign mck_tick    = 1'b1;
   assign mck_cnt_nxt = (mck_cnt_r >= mck_period - 12'h001) ? 12'h000 : mck_cnt_r + 12'h001;
   assign frame_end   = mck_tick && (mck_cnt_r >= mck_period - 12'h001);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mck_cnt_r <= 12'h000;
      else if (mck_tick)
         mck_cnt_r <= mck_cnt_nxt;
   end

   // ratios against the master count; all counts restart on frame_end, aligning edges
   always_comb
   begin
      case (active_sel_r)
         PLLCK_DIV2: conv_div = 4'h8;
         PLLCK_DIV3: conv_div = 4'h4;
         default:    conv_div = 4'h4;
      endcase
      if (active_brown_r)
         conv_div = 4'h4;
      eng_div = conv_div;
      if (active_sel_r == PLLCK_DIV2 && double_act_r)
         eng_div = 4'h4;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || frame_end)
      begin
         sub_cnt_r <= 4'h0;
         cpu_cnt_r <= 9'h000;
      end
      else
      begin
         sub_cnt_r <= (sub_cnt_r == conv_div - 4'h1) ? 4'h0 : sub_cnt_r + 4'h1;
         cpu_cnt_r <= cpu_cnt_r + 9'h001;
      end
   end

   // cpu clock: master over 2^(div+2); emulator at twice that
   assign cpu_mask = 9'((9'h004 << cpu_div_act_r) - 9'h001);

   always_comb
   begin
      en_nxt           = '0;
      en_nxt.master_clock       = mck_tick;
      en_nxt.converter = (sub_cnt_r == 4'h0);
      en_nxt.filter    = (sub_cnt_r == 4'h0);
      en_nxt.engine    = !active_brown_r && (eng_div == 4'h4 ? sub_cnt_r[1:0] == 2'h0
                                                             : sub_cnt_r == 4'h0);
      en_nxt.cpu       = ((cpu_cnt_r & cpu_mask) == 9'h000);
      en_nxt.emulator  = !emu_dis_act_r
                         && ((cpu_cnt_r & (cpu_mask >> 1)) == 9'h000);
      en_nxt.slow32k   = (mck_cnt_r == 12'h000);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_en     <= '0;
         timer_tick <= 1'b0;
      end
      else
      begin
         clk_en     <= en_nxt;
         timer_tick <= en_nxt.cpu;
      end
   end

endmodule : pllck_top
`default_nettype wire

// ===== tb/pllck_consumer.sv
/*
 clock consumer model: counts enable pulses of each derived clock over one 32 kHz frame.
 assumes clk_en pulses last one aclk cycle and slow32k marks the frame start.
*/
`timescale 1ns/10ps
`default_nettype none
module pllck_consumer
   import pllck_pkg::*;
(
   // system
   input  wire logic              aclk,
   // enables from the generator
   input  wire pllck_enables_type clk_en,
   // pulses per full frame, bit order of clk_en
   output var int                 frame_count [7]
);
   int cnt_r [7];

   // the cpu count also stands for the counter/timer clock
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 7; i++)
      begin
         if (clk_en.slow32k)
         begin
            frame_count[i] <= cnt_r[i];
            cnt_r[i]       <= int'(clk_en[i]);
         end
         else
            cnt_r[i] <= cnt_r[i] + int'(clk_en[i]);
      end
   end
endmodule : pllck_consumer
`default_nettype wire

// ===== tb/pllck_top_asserts.sv
/*
 checker for the pll clock generator: pulse spacing, edge alignment and read timing.
 assumes the top module's ports, all on the aclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pllck_asserts
   import pllck_pkg::*;
(
   // system
   input wire logic              aclk,
   input wire logic              aresetn,
   // read handshake
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   // enables
   input wire pllck_enables_type clk_en,
   input wire logic              timer_tick
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // fastest cpu and converter divisions are four master ticks, so three idle cycles follow each pulse
   sequence s_cpu_quiet;
      !clk_en.cpu [*3];
   endsequence
   sequence s_conv_quiet;
      !clk_en.converter [*3];
   endsequence

   AST_TICK_CPU: assert property (timer_tick == clk_en.cpu)
      else $error("timer tick differs from cpu enable");
   AST_ALIGN: assert property (clk_en.slow32k |-> clk_en.converter && clk_en.cpu && clk_en.master_clock)
      else $error("derived edges not aligned");
   AST_FILT: assert property (clk_en.filter == clk_en.converter)
      else $error("filter and converter differ");
   AST_CPU_GAP: assert property (clk_en.cpu |=> s_cpu_quiet)
      else $error("cpu pulses too close");
   AST_CONV_GAP: assert property (clk_en.converter |=> s_conv_quiet)
      else $error("converter pulses too close");
   AST_ENG_GAP: assert property (clk_en.engine |=> !clk_en.engine)
      else $error("engine pulses back to back");
   AST_EMU_GAP: assert property (clk_en.emulator |=> !clk_en.emulator)
      else $error("emulator pulses back to back");
   AST_SLOW_GAP: assert property (clk_en.slow32k |=> !clk_en.slow32k [*8])
      else $error("slow pulses too close");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_AR_HOLD: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during answer");
endmodule : pllck_asserts

bind pllck_top pllck_asserts u_pllck_asserts (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .clk_en, .timer_tick);
`default_nettype wire

// ===== tb/tb_pllck_top.sv
/*
 testbench for the pll clock generator: register access and pulse counts per frame.
 assumes a 20 MHz aclk and the consumer model for counting.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_pllck_top;
   import pllck_pkg::*;
   logic aclk = 0, aresetn = 0, sleep_mode = 0, brownout_mode = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_tick;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   pllck_enables_type clk_en;
   int cnt [7];
   int mismatches = 0, checked = 0;

   pllck_top u_pllck_top (.aclk, .aresetn, .sleep_mode, .brownout_mode, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_en, .timer_tick);
   pllck_consumer u_pllck_consumer (.aclk, .clk_en, .frame_count(cnt));

   initial
   begin
      forever #25 aclk = ~aclk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         n++;
      end
      while (!s_axi_bvalid && n < 50);
      resp = s_axi_bresp;
      s_axi_bready <= 0;
      if (n >= 50) check(1, 0);
   endtask : axi_write

   task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         n++;
      end
      while (!s_axi_rvalid && n < 50);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 0;
      if (n >= 50) check(1, 0);
   endtask : axi_read

   task wait_frame;
      int n;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!clk_en.slow32k && n < 3000);
      if (n >= 3000) check(1, 0);
   endtask : wait_frame

   // em or st below zero: that count or status is not compared
   task run_case(input logic [31:0] ctrl, input logic sl, bo, input int p, cv, en, cp, em, st);
      axi_write(PLLCK_CTRL_OFS, ctrl, r);
      check(r, 2'h0);
      sleep_mode <= sl;
      brownout_mode <= bo;
      repeat (3) wait_frame;
      #1;
      check(cnt[6], p);
      check(cnt[0], 1);
      check(cnt[4], cv);
      check(cnt[3], cv);
      check(cnt[5], en);
      check(cnt[2], cp);
      if (em >= 0) check(cnt[1], em);
      if (st >= 0)
      begin
         axi_read(PLLCK_STATUS_OFS, d, r);
         check(d, st);
      end
      $display("case ctrl %h done", ctrl);
   endtask : run_case

   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      axi_read(PLLCK_CTRL_OFS, d, r);
      check(d, 32'h08);
      axi_read(PLLCK_STATUS_OFS, d, r);
      check(d, 32'h00);
      axi_read(8'h10, d, r);
      check(d, 32'h0);
      check(r, 2'h2);
      axi_write(8'h10, 32'h1, r);
      check(r, 2'h2);
      axi_write(PLLCK_CTRL_OFS, 32'h15, r);
      axi_read(PLLCK_CTRL_OFS, d, r);
      check(d, 32'h15);
      run_case(32'h08, 0, 0, 600, 150, 150, 150, 0, -1);
      run_case(32'h01, 0, 0, 1200, 150, 150, 300, 600, -1);
      run_case(32'h05, 0, 0, 1200, 150, 300, 300, 600, -1);
      run_case(32'h12, 0, 0, 800, 200, 200, 100, 200, -1);
      run_case(32'h01, 1, 0, 600, 150, 150, 150, 300, 8);
      run_case(32'h08, 0, 1, 28, 7, 0, 7, 0, 20);
      results;
   end

   initial
   begin
      repeat (60000) @(posedge aclk);
      mismatches++;
      results;
   end
endmodule : tb_pllck_top
`default_nettype wire
